// File: core/asfp_top.sv
// module: audio sample fifo pair with apb registers and audio serial port sample exchange
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module asfp_top #(
  parameter int unsigned DEPTH = asfp_pkg::ASFP_DEPTH,
  parameter int unsigned DW = asfp_pkg::ASFP_DW
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pacing trigger from timer
  input wire logic trig_pulse,
  // audio serial port side
  output logic frame_start,
  output logic [DW-1:0] tx_left,
  output logic [DW-1:0] tx_right,
  input wire logic [DW-1:0] rx_left,
  input wire logic [DW-1:0] rx_right,
  // interrupt
  output logic irq
);
  localparam int unsigned LW = asfp_pkg::ASFP_LW;

  typedef struct packed {
    logic en;
    logic right;
    logic [LW-1:0] tx_th;
    logic [LW-1:0] rx_th;
    logic [1:0] sel;
    logic [3:0] irq_en;
    logic [3:0] irq_stat;
    logic trig_prev;
    logic frame_start;
    logic [DW-1:0] tx_left;
    logic [DW-1:0] tx_right;
    logic [31:0] prdata;
    logic tx_low_prev;
    logic tx_empty_prev;
    logic rx_high_prev;
    logic pop_ok;
  } asfp_top_st_t;

  asfp_top_st_t st_ff;
  asfp_top_st_t nxt_st;

  logic [DW-1:0] tx_head;
  logic [DW-1:0] rx_head;
  logic [LW-1:0] tx_level;
  logic [LW-1:0] rx_level;
  logic tx_full;
  logic tx_empty;
  logic rx_full;
  logic rx_empty;
  logic trig_rise;
  logic wr_acc;
  logic rd_acc;
  logic sw_push;
  logic sw_pop;
  logic aud_pop;
  logic aud_push;
  logic [DW-1:0] rx_sample;
  logic flush;
  logic setup_rd;
  logic hit_stat;
  logic hit_txd;
  logic hit_rxd;
  logic [31:0] word_ctrl;
  logic [31:0] word_cfg;
  logic [31:0] word_ien;
  logic [31:0] word_stat;
  logic [31:0] word_rxd;
  logic [31:0] word_txl;
  logic [31:0] word_rxl;

  function automatic logic asfp_hit(input logic [7:0] a, input logic [7:0] off);
    asfp_hit = (a == off);
  endfunction : asfp_hit

  // a level event fires on entry to its condition only
  function automatic logic asfp_entry(input logic now, input logic was);
    asfp_entry = now && !was;
  endfunction : asfp_entry

  // apb completes every access in its first access cycle
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pslverr = 1'b0;
  assign prdata = st_ff.prdata;

  assign trig_rise = st_ff.en && trig_pulse && !st_ff.trig_prev;
  assign aud_pop = trig_rise && !tx_empty;
  assign aud_push = trig_rise;
  assign rx_sample = st_ff.right ? rx_right : rx_left;
  assign setup_rd = psel && !penable && !pwrite;
  assign hit_stat = asfp_hit(paddr, asfp_pkg::ASFP_OFF_IRQ_STAT);
  assign hit_txd = asfp_hit(paddr, asfp_pkg::ASFP_OFF_TX_DATA);
  assign hit_rxd = asfp_hit(paddr, asfp_pkg::ASFP_OFF_RX_DATA);
  assign sw_push = st_ff.en && wr_acc && hit_txd;
  // pop only what the setup cycle reported, so a sample landing meanwhile is not lost
  assign sw_pop = st_ff.en && rd_acc && hit_rxd && st_ff.pop_ok;

  // read words, one per register except the tx data register, which reads zero
  assign word_ctrl = {30'h0000_0000, st_ff.right, st_ff.en};
  assign word_cfg = {14'h0000, st_ff.sel, 4'h0, st_ff.rx_th, 4'h0, st_ff.tx_th};
  assign word_ien = {28'h000_0000, st_ff.irq_en};
  assign word_stat = {28'h000_0000, st_ff.irq_stat};
  assign word_rxd = {16'h0000, rx_empty ? 16'h0000 : rx_head};
  assign word_txl = {28'h000_0000, tx_level};
  assign word_rxl = {28'h000_0000, rx_level};
  // disabling drops all held samples so a re-enable starts clean
  assign flush = !st_ff.en;

  assign frame_start = st_ff.frame_start;
  assign tx_left = st_ff.tx_left;
  assign tx_right = st_ff.tx_right;
  assign irq = |(st_ff.irq_stat & st_ff.irq_en);

  asfp_fifo #(.DW(DW), .DEPTH(DEPTH), .LW(LW)) u_tx_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(flush),
    .push(sw_push),
    .push_data(pwdata[DW-1:0]),
    .pop(aud_pop),
    .head_data(tx_head),
    .level(tx_level),
    .full(tx_full),
    .empty(tx_empty)
  );

  asfp_fifo #(.DW(DW), .DEPTH(DEPTH), .LW(LW)) u_rx_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(flush),
    .push(aud_push),
    .push_data(rx_sample),
    .pop(sw_pop),
    .head_data(rx_head),
    .level(rx_level),
    .full(rx_full),
    .empty(rx_empty)
  );

  always_comb
  begin
    logic tx_low;
    logic rx_high;
    logic ovf;
    logic [3:0] set;
    tx_low = 1'b0;
    rx_high = 1'b0;
    ovf = 1'b0;
    set = 4'h0;
    nxt_st = st_ff;
    nxt_st.trig_prev = trig_pulse;
    nxt_st.frame_start = trig_rise;
    if (aud_pop)
    begin
      // sample goes to the chosen slot, the other slot carries zero
      nxt_st.tx_left = st_ff.right ? '0 : tx_head;
      nxt_st.tx_right = st_ff.right ? tx_head : '0;
    end
    else if (trig_rise)
    begin
      // underrun: frame still runs, carrying silence
      nxt_st.tx_left = '0;
      nxt_st.tx_right = '0;
    end

    // level events fire on entry to each condition so a held state does not refire after clear; overflow fires on every dropped rx push
    tx_low = st_ff.en && (tx_level < st_ff.tx_th);
    rx_high = st_ff.en && (rx_level > st_ff.rx_th);
    ovf = aud_push && rx_full && !sw_pop;
    set[asfp_pkg::ASFP_IRQ_TX_LOW] = asfp_entry(tx_low, st_ff.tx_low_prev);
    set[asfp_pkg::ASFP_IRQ_TX_EMPTY] = asfp_entry(st_ff.en && tx_empty, st_ff.tx_empty_prev);
    set[asfp_pkg::ASFP_IRQ_RX_HIGH] = asfp_entry(rx_high, st_ff.rx_high_prev);
    set[asfp_pkg::ASFP_IRQ_RX_OVF] = ovf;
    nxt_st.tx_low_prev = tx_low;
    nxt_st.tx_empty_prev = st_ff.en && tx_empty;
    nxt_st.rx_high_prev = rx_high;

    // read data is captured in the setup cycle, so it stands through the whole access cycle
    if (setup_rd)
    begin
      nxt_st.pop_ok = hit_rxd && !rx_empty;
      unique case (paddr)
        asfp_pkg::ASFP_OFF_CTRL:
          nxt_st.prdata = word_ctrl;
        asfp_pkg::ASFP_OFF_LEVEL_CFG:
          nxt_st.prdata = word_cfg;
        asfp_pkg::ASFP_OFF_IRQ_EN:
          nxt_st.prdata = word_ien;
        asfp_pkg::ASFP_OFF_IRQ_STAT:
          nxt_st.prdata = word_stat;
        asfp_pkg::ASFP_OFF_RX_DATA:
          nxt_st.prdata = word_rxd;
        asfp_pkg::ASFP_OFF_TX_LEVEL:
          nxt_st.prdata = word_txl;
        asfp_pkg::ASFP_OFF_RX_LEVEL:
          nxt_st.prdata = word_rxl;
        default:
          nxt_st.prdata = 32'h0000_0000;
      endcase
    end

    // a status read clears only the bits it reported; a same-cycle event still lands
    if (rd_acc && hit_stat)
    begin
      nxt_st.irq_stat = (st_ff.irq_stat & ~st_ff.prdata[3:0]) | set;
    end
    else
    begin
      nxt_st.irq_stat = st_ff.irq_stat | set;
    end

    if (wr_acc && pstrb[0])
    begin
      if (asfp_hit(paddr, asfp_pkg::ASFP_OFF_CTRL))
      begin
        nxt_st.en = pwdata[asfp_pkg::ASFP_CTRL_EN_BIT];
        nxt_st.right = pwdata[asfp_pkg::ASFP_CTRL_RIGHT_BIT];
      end
      if (asfp_hit(paddr, asfp_pkg::ASFP_OFF_LEVEL_CFG))
      begin
        nxt_st.tx_th = pwdata[asfp_pkg::ASFP_CFG_TXTH_LSB +: LW];
      end
      if (asfp_hit(paddr, asfp_pkg::ASFP_OFF_IRQ_EN))
      begin
        nxt_st.irq_en = pwdata[3:0];
      end
    end
    if (wr_acc && pstrb[1] && asfp_hit(paddr, asfp_pkg::ASFP_OFF_LEVEL_CFG))
    begin
      nxt_st.rx_th = pwdata[asfp_pkg::ASFP_CFG_RXTH_LSB +: LW];
    end
    if (wr_acc && pstrb[2] && asfp_hit(paddr, asfp_pkg::ASFP_OFF_LEVEL_CFG))
    begin
      // only the audio serial port may be attached; other codes are ignored
      if (pwdata[asfp_pkg::ASFP_CFG_SEL_LSB +: 2] == asfp_pkg::ASFP_SEL_AUDIO_PORT)
      begin
        nxt_st.sel = asfp_pkg::ASFP_SEL_AUDIO_PORT;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
      st_ff.en <= asfp_pkg::ASFP_CTRL_RST[0];
      st_ff.right <= asfp_pkg::ASFP_CTRL_RST[1];
      st_ff.tx_th <= asfp_pkg::ASFP_TXTH_RST;
      st_ff.rx_th <= asfp_pkg::ASFP_RXTH_RST;
      st_ff.sel <= asfp_pkg::ASFP_SEL_AUDIO_PORT;
      st_ff.irq_en <= asfp_pkg::ASFP_IRQ_EN_RST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
endmodule : asfp_top
`default_nettype wire

// File: core/asfp_pkg.sv
// package: register map, field layout and reset values of the audio sample fifo pair
package asfp_pkg;
  localparam int unsigned ASFP_DEPTH = 10;
  localparam int unsigned ASFP_DW = 16;
  localparam int unsigned ASFP_LW = 4;

  // byte offsets on apb
  localparam logic [7:0] ASFP_OFF_CTRL = 8'h00;
  localparam logic [7:0] ASFP_OFF_LEVEL_CFG = 8'h04;
  localparam logic [7:0] ASFP_OFF_IRQ_EN = 8'h08;
  localparam logic [7:0] ASFP_OFF_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ASFP_OFF_TX_DATA = 8'h10;
  localparam logic [7:0] ASFP_OFF_RX_DATA = 8'h14;
  localparam logic [7:0] ASFP_OFF_TX_LEVEL = 8'h18;
  localparam logic [7:0] ASFP_OFF_RX_LEVEL = 8'h1C;

  // ctrl fields
  localparam int unsigned ASFP_CTRL_EN_BIT = 0;
  localparam int unsigned ASFP_CTRL_RIGHT_BIT = 1;
  // level_cfg fields
  localparam int unsigned ASFP_CFG_TXTH_LSB = 0;
  localparam int unsigned ASFP_CFG_RXTH_LSB = 8;
  localparam int unsigned ASFP_CFG_SEL_LSB = 16;
  localparam logic [1:0] ASFP_SEL_AUDIO_PORT = 2'h0;
  // interrupt bit positions
  localparam int unsigned ASFP_IRQ_TX_LOW = 0;
  localparam int unsigned ASFP_IRQ_TX_EMPTY = 1;
  localparam int unsigned ASFP_IRQ_RX_HIGH = 2;
  localparam int unsigned ASFP_IRQ_RX_OVF = 3;

  // reset values
  localparam logic [1:0] ASFP_CTRL_RST = 2'h0;
  localparam logic [3:0] ASFP_TXTH_RST = 4'h0;
  localparam logic [3:0] ASFP_RXTH_RST = 4'hA;
  localparam logic [3:0] ASFP_IRQ_EN_RST = 4'h0;
endpackage : asfp_pkg

// File: core/asfp_fifo.sv
// module: one flip-flop sample fifo with push, pop, flush and fill level
`timescale 1ns/1ps
`default_nettype none
module asfp_fifo #(
  parameter int unsigned DW = asfp_pkg::ASFP_DW,
  parameter int unsigned DEPTH = asfp_pkg::ASFP_DEPTH,
  parameter int unsigned LW = asfp_pkg::ASFP_LW
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic flush,
  input wire logic push,
  input wire logic [DW-1:0] push_data,
  input wire logic pop,
  // status
  output logic [DW-1:0] head_data,
  output logic [LW-1:0] level,
  output logic full,
  output logic empty
);
  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [LW-1:0] rd;
    logic [LW-1:0] wr;
    logic [LW-1:0] cnt;
  } asfp_fifo_st_t;

  asfp_fifo_st_t st_ff;
  asfp_fifo_st_t nxt_st;

  function automatic logic [LW-1:0] asfp_inc(input logic [LW-1:0] p);
    asfp_inc = (p == LW'(DEPTH - 1)) ? '0 : p + LW'(1);
  endfunction : asfp_inc

  assign full = (st_ff.cnt == LW'(DEPTH));
  assign empty = (st_ff.cnt == '0);
  assign level = st_ff.cnt;
  assign head_data = st_ff.mem[st_ff.rd];

  // strict first-in first-out: circular write and read pointers
  always_comb
  begin
    logic do_push;
    logic do_pop;
    do_push = 1'b0;
    do_pop = 1'b0;
    nxt_st = st_ff;
    do_pop = pop && !empty;
    do_push = push && (!full || do_pop);
    if (do_push)
    begin
      nxt_st.mem[st_ff.wr] = push_data;
      nxt_st.wr = asfp_inc(st_ff.wr);
    end
    if (do_pop)
    begin
      nxt_st.rd = asfp_inc(st_ff.rd);
    end
    nxt_st.cnt = st_ff.cnt + LW'(do_push) - LW'(do_pop);
    if (flush)
    begin
      nxt_st.rd = '0;
      nxt_st.wr = '0;
      nxt_st.cnt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end
endmodule : asfp_fifo
`default_nettype wire

// File: tb/asfp_top_assertions.sv
// checker: port-level properties of the audio sample fifo pair
`timescale 1ns/1ps
`default_nettype none
module asfp_top_assertions #(
  parameter int unsigned DW = 16
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // audio side
  input wire logic trig_pulse,
  input wire logic frame_start,
  input wire logic [DW-1:0] tx_left,
  input wire logic [DW-1:0] tx_right,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic rd = psel && penable && !pwrite;

  chk_apb_answer: assert property (psel && penable |-> pready && !pslverr)
    else $error("apb access not answered cleanly");
  chk_pulse_once: assert property (frame_start |=> !frame_start)
    else $error("frame start longer than one cycle");
  chk_frame_cause: assert property (frame_start |-> $past(trig_pulse) && !$past(trig_pulse, 2))
    else $error("frame start without trigger rise");
  chk_tx_stand: assert property (!frame_start |-> $stable(tx_left) && $stable(tx_right))
    else $error("frame data moved between frames");
  chk_one_slot: assert property (frame_start |-> tx_left == '0 || tx_right == '0)
    else $error("sample in both channel slots");
  chk_irq_rise: assert property ($rose(irq) |-> frame_start || $past(frame_start)
    || $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
    else $error("interrupt rose without cause");
  chk_unmapped_zero: assert property (rd && paddr >= 8'h20 |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_level_bound: assert property (rd && paddr >= 8'h18 && paddr <= 8'h1C |-> prdata <= 32'h0000_000A)
    else $error("fill level above ten");
endmodule : asfp_top_assertions

bind asfp_top asfp_top_assertions #(.DW(DW)) asfp_top_assertions_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_pulse(trig_pulse),
  .frame_start(frame_start), .tx_left(tx_left), .tx_right(tx_right), .irq(irq)
);
`default_nettype wire

// File: tb/asfp_audio_model.sv
// partner: audio serial port model answering each frame start
`timescale 1ns/1ps
`default_nettype none
module asfp_audio_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // frame exchange
  input wire logic frame_start,
  output logic [15:0] rx_left,
  output logic [15:0] rx_right
);
  logic [7:0] frame_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_ff <= 8'h00;
    else if (frame_start)
      frame_ff <= frame_ff + 8'h01;
  end
  // distinct slot patterns reveal which channel was taken
  assign rx_left = {8'hA5, frame_ff};
  assign rx_right = {8'h5B, frame_ff};
endmodule : asfp_audio_model
`default_nettype wire

// File: tb/asfp_top_tb.sv
// testbench: apb and trigger sequences for the audio sample fifo pair
`timescale 1ns/1ps
`default_nettype none
module asfp_top_tb;
  localparam logic [7:0] CTL = asfp_pkg::ASFP_OFF_CTRL;
  localparam logic [7:0] IEN = asfp_pkg::ASFP_OFF_IRQ_EN;
  localparam logic [7:0] IST = asfp_pkg::ASFP_OFF_IRQ_STAT;
  localparam logic [7:0] TXD = asfp_pkg::ASFP_OFF_TX_DATA;
  localparam logic [7:0] RXD = asfp_pkg::ASFP_OFF_RX_DATA;
  localparam logic [7:0] TXL = asfp_pkg::ASFP_OFF_TX_LEVEL;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic trig_pulse = 1'b0;
  logic [31:0] prdata, v;
  logic pready, pslverr, frame_start, irq;
  logic [15:0] tx_left, tx_right, rx_left, rx_right;
  int fails = 0;
  int checks = 0;

  always #2.5 pclk = ~pclk;

  asfp_top asfp_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_pulse(trig_pulse), .frame_start(frame_start), .tx_left(tx_left),
    .tx_right(tx_right), .rx_left(rx_left), .rx_right(rx_right), .irq(irq)
  );
  asfp_audio_model asfp_audio_model_inst (
    .pclk(pclk), .presetn(presetn), .frame_start(frame_start), .rx_left(rx_left), .rx_right(rx_right)
  );

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // read data stands through the access cycle and is taken at the edge that completes it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    v = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), v, e);
  endtask : rd

  task automatic trig(input logic f, input logic [15:0] l, input logic [15:0] r);
    trig_pulse <= 1'b1;
    @(posedge pclk);
    trig_pulse <= 1'b0;
    #1 chk("frame_start", {31'h0, frame_start}, {31'h0, f});
    chk("tx_left", {16'h0000, tx_left}, {16'h0000, l});
    chk("tx_right", {16'h0000, tx_right}, {16'h0000, r});
    @(posedge pclk);
  endtask : trig

  task automatic cki(input logic e);
    #1 chk("irq", {31'h0, irq}, {31'h0, e});
    @(posedge pclk);
  endtask : cki

  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(CTL, 32'h0000_0000);
    rd(asfp_pkg::ASFP_OFF_LEVEL_CFG, 32'h0000_0A00);
    rd(IEN, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    xfer(1'b1, TXD, 32'h0000_1234);
    rd(TXL, 32'h0000_0000);
    trig(1'b0, 16'h0000, 16'h0000);
    $display("test reset done");
    xfer(1'b1, CTL, 32'h0000_0001);
    xfer(1'b1, asfp_pkg::ASFP_OFF_LEVEL_CFG, 32'h0000_0703);
    xfer(1'b1, asfp_pkg::ASFP_OFF_LEVEL_CFG, 32'h0001_0703);
    rd(asfp_pkg::ASFP_OFF_LEVEL_CFG, 32'h0000_0703);
    xfer(1'b1, IEN, 32'h0000_000F);
    for (int i = 0; i < 11; i++)
      xfer(1'b1, TXD, 32'h0000_1000 + i);
    rd(TXL, 32'h0000_000A);
    rd(IST, 32'h0000_0003);
    cki(1'b0);
    for (int i = 0; i < 11; i++)
      trig(1'b1, (i < 10) ? 16'h1000 + 16'(i) : 16'h0000, 16'h0000);
    rd(asfp_pkg::ASFP_OFF_RX_LEVEL, 32'h0000_000A);
    cki(1'b1);
    rd(IST, 32'h0000_000F);
    rd(IST, 32'h0000_0000);
    for (int i = 0; i < 10; i++)
      rd(RXD, 32'h0000_A500 + i);
    rd(RXD, 32'h0000_0000);
    $display("test stream done");
    xfer(1'b1, IEN, 32'h0000_0008);
    xfer(1'b1, CTL, 32'h0000_0003);
    xfer(1'b1, TXD, 32'h0000_2222);
    trig(1'b1, 16'h0000, 16'h2222);
    cki(1'b0);
    xfer(1'b1, IEN, 32'h0000_0002);
    cki(1'b1);
    xfer(1'b0, IST, 32'h0000_0000);
    chk("tx_empty", {31'h0, v[1]}, 32'h0000_0001);
    cki(1'b0);
    rd(RXD, 32'h0000_5B0B);
    $display("test channel done");
    xfer(1'b1, TXD, 32'h0000_3333);
    xfer(1'b1, CTL, 32'h0000_0000);
    xfer(1'b1, CTL, 32'h0000_0001);
    rd(TXL, 32'h0000_0000);
    $display("test disable done");
    finish_test();
  end

  // the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    finish_test();
  end
endmodule : asfp_top_tb
`default_nettype wire
